/* File: common/pmsc_regs.svh */
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH
// ==========================================
// Register offsets
`define PMSC_OFS_CTRL      8'hC0
`define PMSC_OFS_SRC_ADDR  8'hC1
`define PMSC_OFS_STATUS    8'hC2
`define PMSC_OFS_SWPC      8'hC3
`define PMSC_OFS_FLAGS     8'hC5
`define PMSC_OFS_IRQ_STAT  8'hC8
`define PMSC_OFS_IRQ_EN    8'hC9
`define PMSC_OFS_IRQ_CLR   8'hCA
// ==========================================
// Field positions
`define PMSC_BIT_PRESS_EN  7
`define PMSC_BIT_REL_EN    6
`define PMSC_BIT_WDSR_EN   1
`define PMSC_BIT_WDPC_EN   0
`define PMSC_BIT_PRESS_ST  7
`define PMSC_BIT_REL_ST    6
`define PMSC_BIT_LIVE      5
`define PMSC_BIT_SWPC      0
`define PMSC_BIT_PC_FLAG   1
`define PMSC_BIT_SR_FLAG   0
`define PMSC_BIT_CLR_PRESS 0
`define PMSC_BIT_CLR_REL   1
// ==========================================
// Reset values and timing
`define PMSC_SRC_ADDR_RST  8'hFF
`define PMSC_BYTE_ZERO     8'h00
`define PMSC_IRQ_W         4
`define PMSC_SWPC_DELAY_NS 8000000
`define PMSC_CLK_PERIOD_NS 40
`endif

/* File: common/pmsc_pkg.sv */
package pmsc_pkg;
  typedef logic [7:0] pmsc_byte_t;
  typedef logic [7:0] pmsc_addr_t;
  // Power sequencer states, Gray from idle through wait to cycle; cycle back to idle flips both bits
  typedef enum logic [1:0] {
    PMSC_IDLE  = 2'b00,
    PMSC_WAIT  = 2'b01,
    PMSC_CYCLE = 2'b11
  } pmsc_seq_e;
endpackage

/* File: hdl/pmsc_sync.sv */
`timescale 1ns/100ps
// ==========================================
// Two-flop synchroniser
module pmsc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  // Data
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_r;
  // Only the second flop is read outside; reset to the pin's idle level avoids a false edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end else if (i_ce) begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

/* File: hdl/pmsc_delay.sv */
`timescale 1ns/100ps
// ==========================================
// One-shot delay timer, pulses o_done after CYCLES
module pmsc_delay #(
  parameter int CYCLES = 200000
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  // Control
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;
  wire           last = (cnt_r == CW'(1));
  assign o_busy = (cnt_r != '0);
  // Counter loads on start, done pulses on the final count
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r  <= '0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= o_busy && last;
      if (i_start && !o_busy) begin
        cnt_r <= CW'(CYCLES);
      end else if (o_busy) begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end
endmodule

/* File: hdl/pmsc_top.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "pmsc_regs.svh"
// Operation
// - Watchdog expiry with enable starts soft reset
// - Watchdog expiry with enable starts power cycle
// - Sleep entry clears both watchdog enables
// - Source address byte reads, resets 0xFF
// - Reading source address reloads 0xFF
// - Press status bit set on press interrupt
// - Release status bit set on release interrupt
// - Live button level shown in status
// - Software request waits 8ms, then power cycles
// - Power-cycle flag set, cleared on read
// - Soft-reset flag set, cleared on read
// - Press enable raises interrupt on press
// - Release enable raises interrupt on release
module pmsc_top #(
  parameter int SWPC_CYCLES = (`PMSC_SWPC_DELAY_NS + `PMSC_CLK_PERIOD_NS - 1) / `PMSC_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input  wire logic           i_clk,
  input  wire logic           i_resetn,
  input  wire logic           i_ce,
  // Register port
  input  wire pmsc_pkg::pmsc_addr_t i_addr,
  input  wire pmsc_pkg::pmsc_byte_t i_wdata,
  input  wire logic           i_wr,
  input  wire logic           i_rd,
  output pmsc_pkg::pmsc_byte_t o_rdata,
  // System events
  input  wire logic           i_button_n,
  input  wire logic           i_wdog_expire,
  input  wire logic           i_sleep_entry,
  input  wire pmsc_pkg::pmsc_byte_t i_int_source,
  input  wire logic           i_int_source_vld,
  // Sequencer requests
  output logic                o_soft_reset,
  output logic                o_power_cycle,
  // Interrupts
  output logic                o_irq,
  output logic                o_irq_n_out,
  output logic                o_irq_n_oe
);
  import pmsc_pkg::*;

  // ==========================================
  // Pin synchronisation
  logic btn_n_s;
  // Starts at the released level so leaving reset does not fake a press
  pmsc_sync #(.RST_VAL(1'b1)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_d      (i_button_n),
    .o_q      (btn_n_s)
  );
  wire   live = ~btn_n_s;
  logic  live_r;

  // ==========================================
  // Decode
  wire wr_ctrl   = i_wr && (i_addr == `PMSC_OFS_CTRL);
  wire wr_swpc   = i_wr && (i_addr == `PMSC_OFS_SWPC);
  wire wr_irq_en = i_wr && (i_addr == `PMSC_OFS_IRQ_EN);
  wire wr_irq_cl = i_wr && (i_addr == `PMSC_OFS_IRQ_CLR);
  wire rd_src_addr = i_rd && (i_addr == `PMSC_OFS_SRC_ADDR);
  wire rd_flags  = i_rd && (i_addr == `PMSC_OFS_FLAGS);

  // ==========================================
  // Registers
  logic       press_en_r, rel_en_r, wdsr_en_r, wdpc_en_r;
  pmsc_byte_t src_addr_r;
  logic       press_st_r, rel_st_r, swpc_r;
  logic       pc_flag_r, sr_flag_r;
  logic [`PMSC_IRQ_W-1:0] irq_st_r, irq_en_r;
  pmsc_byte_t rdata_r;
  pmsc_seq_e  seq_r;

  // Button edges
  wire press_ev   = live && !live_r;
  wire release_ev = !live && live_r;
  wire press_irq  = press_ev && press_en_r;
  wire rel_irq    = release_ev && rel_en_r;
  wire wd_sr      = i_wdog_expire && wdsr_en_r;
  wire wd_pc      = i_wdog_expire && wdpc_en_r;

  // Delay timer for software power cycle
  logic dly_busy, dly_done;
  pmsc_delay #(.CYCLES(SWPC_CYCLES)) u_delay (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_start  (seq_r == PMSC_IDLE && swpc_r),
    .o_busy   (dly_busy),
    .o_done   (dly_done)
  );

  // Sequencer: idle, wait 8ms, one-cycle power cycle request
  pmsc_seq_e seq_nxt;
  always_comb begin
    seq_nxt = seq_r;
    unique case (seq_r)
      PMSC_IDLE:  if (swpc_r) seq_nxt = PMSC_WAIT;
      PMSC_WAIT:  if (dly_done) seq_nxt = PMSC_CYCLE;
      PMSC_CYCLE: seq_nxt = PMSC_IDLE;
      default:    seq_nxt = PMSC_IDLE;
    endcase
  end
  wire sw_pc = (seq_r == PMSC_CYCLE);
  wire pc_ev = wd_pc || sw_pc;

  // Control byte; sleep wins over a same-cycle write of the watchdog bits
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      press_en_r <= 1'b0;
      rel_en_r   <= 1'b0;
      wdsr_en_r  <= 1'b0;
      wdpc_en_r  <= 1'b0;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        press_en_r <= i_wdata[`PMSC_BIT_PRESS_EN];
        rel_en_r   <= i_wdata[`PMSC_BIT_REL_EN];
        wdsr_en_r  <= i_wdata[`PMSC_BIT_WDSR_EN];
        wdpc_en_r  <= i_wdata[`PMSC_BIT_WDPC_EN];
      end
      if (i_sleep_entry) begin
        wdsr_en_r <= 1'b0;
        wdpc_en_r <= 1'b0;
      end
    end
  end

  // Interrupt source; new source wins over reload on read
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      src_addr_r <= `PMSC_SRC_ADDR_RST;
    end else if (i_ce) begin
      if (i_int_source_vld) begin
        src_addr_r <= i_int_source;
      end else if (rd_src_addr) begin
        src_addr_r <= `PMSC_SRC_ADDR_RST;
      end
    end
  end

  // Button status: sticky, cleared by host via the interrupt clear register
  wire clr_press = wr_irq_cl && i_wdata[`PMSC_BIT_CLR_PRESS];
  wire clr_rel   = wr_irq_cl && i_wdata[`PMSC_BIT_CLR_REL];
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      live_r     <= 1'b0;
      press_st_r <= 1'b0;
      rel_st_r   <= 1'b0;
    end else if (i_ce) begin
      live_r     <= live;
      press_st_r <= press_irq | (press_st_r & ~clr_press);
      rel_st_r   <= rel_irq | (rel_st_r & ~clr_rel);
    end
  end

  // Software request bit self-clears once the sequencer takes it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      swpc_r <= 1'b0;
      seq_r  <= PMSC_IDLE;
    end else if (i_ce) begin
      seq_r <= seq_nxt;
      if (wr_swpc && i_wdata[`PMSC_BIT_SWPC]) begin
        swpc_r <= 1'b1;
      end else if (seq_r == PMSC_IDLE) begin
        swpc_r <= 1'b0;
      end
    end
  end

  // Reset cause flags: a new event wins over clear on read
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_flag_r <= 1'b0;
      sr_flag_r <= 1'b0;
    end else if (i_ce) begin
      pc_flag_r <= pc_ev | (pc_flag_r & ~rd_flags);
      sr_flag_r <= wd_sr | (sr_flag_r & ~rd_flags);
    end
  end

  // Interrupt bank: press, release, soft reset, power cycle
  wire [`PMSC_IRQ_W-1:0] irq_ev = {pc_ev, wd_sr, rel_irq, press_irq};
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_st_r <= '0;
      irq_en_r <= '0;
    end else if (i_ce) begin
      irq_st_r <= irq_ev | (irq_st_r & ~(wr_irq_cl ? i_wdata[`PMSC_IRQ_W-1:0] : '0));
      if (wr_irq_en) begin
        irq_en_r <= i_wdata[`PMSC_IRQ_W-1:0];
      end
    end
  end

  // Read mux
  pmsc_byte_t rd_mux;
  always_comb begin
    rd_mux = `PMSC_BYTE_ZERO;
    unique case (i_addr)
      `PMSC_OFS_CTRL:     rd_mux = {press_en_r, rel_en_r, 4'h0, wdsr_en_r, wdpc_en_r};
      `PMSC_OFS_SRC_ADDR: rd_mux = src_addr_r;
      `PMSC_OFS_STATUS:   rd_mux = {press_st_r, rel_st_r, live, 5'h00};
      `PMSC_OFS_SWPC:     rd_mux = {7'h00, swpc_r};
      `PMSC_OFS_FLAGS:    rd_mux = {6'h00, pc_flag_r, sr_flag_r};
      `PMSC_OFS_IRQ_STAT: rd_mux = {4'h0, irq_st_r};
      `PMSC_OFS_IRQ_EN:   rd_mux = {4'h0, irq_en_r};
      default:            rd_mux = `PMSC_BYTE_ZERO;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= `PMSC_BYTE_ZERO;
    end else if (i_ce) begin
      rdata_r <= i_rd ? rd_mux : `PMSC_BYTE_ZERO;
    end
  end

  // ==========================================
  // Outputs
  assign o_rdata       = rdata_r;
  assign o_soft_reset  = wd_sr;
  assign o_power_cycle = pc_ev;
  assign o_irq         = |(irq_st_r & irq_en_r);
  // Open drain: driven low only, never driven high
  assign o_irq_n_out   = 1'b0;
  assign o_irq_n_oe    = press_st_r | rel_st_r;

  // ==========================================
  // Assertions
  // Cycles spent waiting; lets the delay check cover the full count, not just a few cycles
  logic [31:0] wait_cnt_r;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_cnt_r <= 32'h0;
    end else if (i_ce) begin
      wait_cnt_r <= (seq_r == PMSC_WAIT) ? wait_cnt_r + 32'h1 : 32'h0;
    end
  end
  a_sleep_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_sleep_entry |=> !wdsr_en_r && !wdpc_en_r) else $error("sleep did not clear");
  a_src_reload: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && rd_src_addr && !i_int_source_vld |=> src_addr_r == `PMSC_SRC_ADDR_RST) else $error("no reload");
  a_src_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_int_source_vld |=> src_addr_r == $past(i_int_source)) else $error("source not loaded");
  a_press_sets: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && press_irq |=> press_st_r) else $error("press status lost");
  a_release_sets: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && rel_irq |=> rel_st_r) else $error("release status lost");
  a_live_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_rd && i_addr == `PMSC_OFS_STATUS |=> o_rdata[`PMSC_BIT_LIVE] == $past(live)) else $error("live wrong");
  a_swpc_delay: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sw_pc |-> wait_cnt_r >= 32'(SWPC_CYCLES)) else $error("early power cycle");
  a_pc_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && pc_ev |=> pc_flag_r) else $error("pc flag not set");
  a_sr_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && wd_sr |=> sr_flag_r) else $error("sr flag not set");
  a_wd_reset: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_wdog_expire && wdsr_en_r |-> o_soft_reset) else $error("no soft reset");
  a_wd_power: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_wdog_expire && wdpc_en_r |-> o_power_cycle) else $error("no power cycle");
  a_irq_pin: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (press_st_r || rel_st_r) |-> o_irq_n_oe && !o_irq_n_out) else $error("irq pin idle");
  c_press: cover property (@(posedge i_clk) press_irq);
  c_swpc: cover property (@(posedge i_clk) sw_pc);
  c_flags_read: cover property (@(posedge i_clk) rd_flags && pc_flag_r);
  c_release: cover property (@(posedge i_clk) rel_irq);
  c_wdog: cover property (@(posedge i_clk) wd_sr);
endmodule

/* File: tb/pmsc_host.sv */
`timescale 1ns/100ps
// ==========================================
// Host model: register master, one strobe a cycle, never waits
module pmsc_host (
  // Clock and read data
  input  wire logic                 i_clk,
  input  wire pmsc_pkg::pmsc_byte_t i_rdata,
  // Register port
  output pmsc_pkg::pmsc_addr_t      o_addr,
  output pmsc_pkg::pmsc_byte_t      o_wdata,
  output logic                      o_wr,
  output logic                      o_rd
);
  import pmsc_pkg::*;
  // Idle bus at time zero
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // One-cycle write strobe beside address and data
  task automatic wr_reg(input pmsc_addr_t a, input pmsc_byte_t d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just then
  task automatic rd_reg(input pmsc_addr_t a, output pmsc_byte_t d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule

/* File: tb/pmsc_top_test.sv */
`timescale 1ns/100ps
`include "pmsc_regs.svh"
// ==========================================
// Self-checking bench for the system-control bank
module pmsc_top_test;
  import pmsc_pkg::*;
  localparam int SWPC = 20;
  logic       i_clk = 1'b0;
  logic       i_resetn = 1'b0;
  logic       ce = 1'b1;
  logic       irq_n_out;
  logic       btn_n = 1'b1;
  logic       wdog = 1'b0;
  logic       sleep = 1'b0;
  logic       src_vld = 1'b0;
  pmsc_byte_t src = 8'h00;
  pmsc_addr_t addr;
  pmsc_byte_t wdata;
  pmsc_byte_t rdata;
  pmsc_byte_t rv;
  logic       wr;
  logic       rd;
  logic       soft_rst;
  logic       pwr_cyc;
  logic       irq;
  logic       irq_oe;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         n;
  // 25 MHz clock
  always #20 i_clk = ~i_clk;
  pmsc_host i_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  // Short request delay keeps the run brief
  pmsc_top #(.SWPC_CYCLES(SWPC)) i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_button_n(btn_n), .i_wdog_expire(wdog), .i_sleep_entry(sleep), .i_int_source(src),
    .i_int_source_vld(src_vld), .o_soft_reset(soft_rst), .o_power_cycle(pwr_cyc), .o_irq(irq),
    .o_irq_n_out(irq_n_out), .o_irq_n_oe(irq_oe));
  // ==========================================
  // Shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input pmsc_addr_t a, input pmsc_byte_t exp);
    i_host.rd_reg(a, rv);
    chk(rv, exp);
  endtask
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_src_addr;
    rd_chk(`PMSC_OFS_SRC_ADDR, 8'hFF);
    rd_chk(8'hC4, 8'h00);
    @(posedge i_clk);
    src     <= 8'h5A;
    src_vld <= 1'b1;
    @(posedge i_clk);
    src_vld <= 1'b0;
    rd_chk(`PMSC_OFS_SRC_ADDR, 8'h5A);
    rd_chk(`PMSC_OFS_SRC_ADDR, 8'hFF);
    $display("test source address done");
  endtask
  task automatic t_button;
    i_host.wr_reg(`PMSC_OFS_IRQ_EN, 8'h03);
    i_host.wr_reg(`PMSC_OFS_CTRL, 8'hC0);
    @(posedge i_clk) btn_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    rd_chk(`PMSC_OFS_STATUS, 8'hA0);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, irq_oe}, 8'h01);
    chk({7'h00, irq_n_out}, 8'h00);
    @(posedge i_clk) btn_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    rd_chk(`PMSC_OFS_STATUS, 8'hC0);
    rd_chk(`PMSC_OFS_IRQ_STAT, 8'h03);
    i_host.wr_reg(`PMSC_OFS_IRQ_CLR, 8'h03);
    rd_chk(`PMSC_OFS_STATUS, 8'h00);
    chk({6'h00, irq_oe, irq}, 8'h00);
    // Masked press still shows the live level
    i_host.wr_reg(`PMSC_OFS_CTRL, 8'h00);
    @(posedge i_clk) btn_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    rd_chk(`PMSC_OFS_STATUS, 8'h20);
    chk({7'h00, irq}, 8'h00);
    @(posedge i_clk) btn_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    rd_chk(`PMSC_OFS_STATUS, 8'h00);
    rd_chk(`PMSC_OFS_IRQ_STAT, 8'h00);
    $display("test button done");
  endtask
  task automatic t_wdog;
    i_host.wr_reg(`PMSC_OFS_CTRL, 8'h03);
    @(posedge i_clk) wdog <= 1'b1;
    #1 chk({6'h00, pwr_cyc, soft_rst}, 8'h03);
    @(posedge i_clk) wdog <= 1'b0;
    rd_chk(`PMSC_OFS_FLAGS, 8'h03);
    rd_chk(`PMSC_OFS_FLAGS, 8'h00);
    // Soft-reset enable alone must not power cycle
    i_host.wr_reg(`PMSC_OFS_CTRL, 8'h02);
    @(posedge i_clk) wdog <= 1'b1;
    #1 chk({6'h00, pwr_cyc, soft_rst}, 8'h01);
    @(posedge i_clk) wdog <= 1'b0;
    rd_chk(`PMSC_OFS_FLAGS, 8'h01);
    i_host.wr_reg(`PMSC_OFS_CTRL, 8'h03);
    @(posedge i_clk) sleep <= 1'b1;
    @(posedge i_clk) sleep <= 1'b0;
    rd_chk(`PMSC_OFS_CTRL, 8'h00);
    @(posedge i_clk) wdog <= 1'b1;
    #1 chk({6'h00, pwr_cyc, soft_rst}, 8'h00);
    @(posedge i_clk) wdog <= 1'b0;
    $display("test watchdog done");
  endtask
  // A write while the enable is low must not land
  task automatic t_ce;
    @(posedge i_clk) ce <= 1'b0;
    i_host.wr_reg(`PMSC_OFS_CTRL, 8'h02);
    @(posedge i_clk) ce <= 1'b1;
    rd_chk(`PMSC_OFS_CTRL, 8'h00);
    $display("test clock enable done");
  endtask
  task automatic t_swpc;
    i_host.wr_reg(`PMSC_OFS_SWPC, 8'h01);
    n = 0;
    while (pwr_cyc !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= 200) begin
      miscompares++;
      close_out();
    end
    // Delay may carry a few cycles of pipeline beyond the count
    chk({7'h00, (n >= SWPC && n <= SWPC + 4)}, 8'h01);
    rd_chk(`PMSC_OFS_FLAGS, 8'h02);
    $display("test sw power cycle done");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_src_addr();
    t_button();
    t_wdog();
    t_ce();
    t_swpc();
    close_out();
  end
endmodule
